// ---- logic/sff_cfg.svh ----
// Constants of the sensor frame queue: register offsets, field positions,
// reset values, header encodings and timing counts.
// Assumes inclusion by bare name from the top module, the checker and the bench.
`ifndef SFF_CFG_SVH
`define SFF_CFG_SVH
// Register byte offsets on APB
`define SFF_A_CONFIG   12'h000
`define SFF_A_CMD      12'h004
`define SFF_A_LEN_LO   12'h008
`define SFF_A_LEN_HI   12'h00C
`define SFF_A_DATA     12'h010
`define SFF_A_WTM_LO   12'h014
`define SFF_A_WTM_HI   12'h018
`define SFF_A_STATUS   12'h01C
// Configuration register fields
`define SFF_B_HDR      0
`define SFF_B_STOP     1
`define SFF_B_TIME     2
`define SFF_B_ACC      3
`define SFF_B_AUX      4
`define SFF_B_TAG1     5
`define SFF_B_TAG2     6
`define SFF_B_IN1      7
`define SFF_B_IN2      8
`define SFF_B_BURST    9
`define SFF_B_UNF      12
`define SFF_B_DOWNS    13
`define SFF_CFG_RST    16'h0009
// Status register fields
`define SFF_S_FULL     0
`define SFF_S_WTM      1
`define SFF_S_ERR      2
// Commands, sizes and thresholds
`define SFF_CMD_FLUSH  8'hB0
`define SFF_DEPTH      11'd1024
`define SFF_MAX_FRAME  11'd17
`define SFF_FULL_THR   11'd994
`define SFF_AUX_BYTES  5'd8
`define SFF_ACC_BYTES  5'd6
// Header encodings
`define SFF_HDR_REG    2'b10
`define SFF_HDR_CTL    2'b01
`define SFF_OP_SKIP    4'h0
`define SFF_OP_TIME    4'h1
`define SFF_OP_ICFG    4'h2
`define SFF_OP_DROP    4'h4
`define SFF_INVALID    8'h80
// Idle cycles without bus activity that end a read burst
`define SFF_BURST_IDLE 4'd8
`endif

// ---- logic/sff_pkg.sv ----
// Types of the sensor frame queue: sensor-side carriers and state enums.
// Assumes the constants header is on the include path.
package sff_pkg;
  // Sample ticks and data from the sensor core, one clock per tick
  typedef struct packed {
    logic        filt_tick;
    logic        raw_tick;
    logic        aux_tick;
    logic [47:0] acc_xyz;
    logic [63:0] aux_bytes;
  } sff_sample_t;
  // Configuration change and sample drop events
  typedef struct packed {
    logic       chg_valid;
    logic [3:0] chg_bits;
    logic       drop_valid;
    logic [1:0] drop_bits;
  } sff_event_t;
  typedef enum logic [1:0] {WS_IDLE, WS_EVICT, WS_WRITE} sff_wstate_t;
  typedef enum logic [1:0] {RS_DATA, RS_SKIP, RS_TIME, RS_OVER} sff_rstate_t;
endpackage : sff_pkg

// ---- logic/sff_top.sv ----
// Frame queue of a triaxial acceleration sensor with APB register access.
// Assumes sensor ticks are one-cycle pulses on a grid shared by all sources
// and that pin levels are already synchronous to clk_sys.
`timescale 1ns/1ps
`include "sff_cfg.svh"

// Behaviour
// [R01] Header enable bit may switch headers off; headerless stores regular frames only.
// [R02] Headerless frame size or order changes flush the queue at once.
// [R03] Aux slot is eight bytes, burst count filled, rest padded; then X, Y, Z.
// [R04] Frames are captured at the fastest enabled source rate.
// [R05] Unfiltered select takes the 1600 Hz tick; input rate divided by 2^k.
// [R06] Overwrite mode deletes oldest frames; skip frame is announced in header mode.
// [R07] Stop mode discards the newest frame when free space is below maximum.
// [R08] During a host read new data is dropped and the error flag set; done only below 17 free bytes, a frame that fits is written.
// [R09] Control frames only in header mode, chosen by opcode.
// [R10] Fill level in bytes over two registers; sensortime frames not counted.
// [R11] After overflow a skip frame leads the next burst, count saturating.
// [R12] Sensortime frame appended when the queue empties in a burst.
// [R13] Input configuration frame with change bits precedes the new setting.
// [R14] Sample drop frame after a configuration frame on a tick without data.
// [R15] A partly read frame is returned whole on the next burst.
// [R16] Overreads return 0x8000 headerless and 0x0080 in header mode.
// [R17] All sources share one grid; transitions may lack some sources.
// [R18] Enabled pin levels are copied into the header tag field.
// [R19] Full interrupt when fill level exceeds the full threshold.
// [R20] Watermark interrupt when fill level reaches the watermark.
// [R21] Interrupts suppressed in a burst; latched flags clear on read below threshold.
// [R22] Flush by command 0xB0 and automatically on size-affecting changes.
// [R23] Header holds kind in 7:6, mask or opcode in 5:2, tags in 1:0.
// [R24] Storage holds 1024 bytes.
module sff_top (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire sff_pkg::sff_sample_t smp,
  input  wire sff_pkg::sff_event_t  evt,
  input  wire logic [23:0]        sensortime,
  input  wire logic               pin1_level,
  input  wire logic               pin2_level,
  output logic                    irq_full,
  output logic                    irq_wtm
);
  import sff_pkg::*;

  logic [7:0]  mem [1024];                 // [R24]
  logic [7:0]  stg_q [17];
  logic [7:0]  stg_d [17];
  logic [15:0] cfg_q, cfg_d;
  logic [13:0] wtm_q, wtm_d;
  logic [31:0] prdata_q, prdata_d;
  logic [10:0] wr_q, wr_d, rd_q, rd_d, cur_q, cur_d;
  logic [10:0] count, free;
  logic [4:0]  rem_q, rem_d, rem_n, len_q, len_d, wi_q, wi_d, hl_len;
  logic [7:0]  skip_q, skip_d, rbyte, ovb, mem_wd;
  logic [23:0] tm_q, tm_d;
  logic [6:0]  ds_q, ds_d, ds_mask;
  logic [3:0]  pend_q, pend_d, idle_q, idle_d;
  logic [3:0]  adsel;
  logic [1:0]  ri_q, ri_d, ri_e, tag;
  logic [9:0]  mem_wa;
  sff_wstate_t ws_q, ws_d;
  sff_rstate_t rs_q, rs_d, rs_e;
  logic        ov_q, ov_d, burst_q, burst_d, trn_q, trn_d;
  logic        full_q, full_d, wtmf_q, wtmf_d, err_q, err_d;
  logic        acc_ph, wr_en, rd_en, setup, data_sel, data_rd, mapped;
  logic        hdr_en, stop_en, time_en, acc_en, aux_en, unf_en;
  logic        acc_src, acc_take, aux_take, tick, drop_ok, inc_aux, inc_acc;
  logic        flush, cfg_wr, lvl_full, lvl_wtm, have, mem_we, skip_inc, err_set;
  logic [2:0]  burst_n, downs;
  int          n;

  // Frame length from a header byte, or the fixed headerless size
  function automatic logic [4:0] flen(input logic [7:0] h, input logic hm, input logic [4:0] hl);
    if (!hm) begin
      flen = hl;
    end else if (h[7:6] == `SFF_HDR_CTL) begin
      flen = 5'd2;
    end else begin
      flen = 5'd1 + (h[4] ? `SFF_AUX_BYTES : 5'd0) + (h[2] ? `SFF_ACC_BYTES : 5'd0);
    end
  endfunction : flen

  // APB phases; zero wait states, read data registered in the setup cycle
  assign setup    = psel & ~penable;
  assign acc_ph   = psel & penable;
  assign pready   = acc_ph;
  assign wr_en    = acc_ph & pwrite;
  assign rd_en    = acc_ph & ~pwrite;
  assign data_sel = psel & ~pwrite & (paddr == `SFF_A_DATA);
  assign data_rd  = rd_en & (paddr == `SFF_A_DATA);
  assign adsel    = paddr[5:2];
  assign mapped   = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00);
  assign pslverr  = acc_ph & ~mapped;
  assign prdata   = prdata_q;

  // Configuration fields
  assign hdr_en  = cfg_q[`SFF_B_HDR];      // [R01]
  assign stop_en = cfg_q[`SFF_B_STOP];
  assign time_en = cfg_q[`SFF_B_TIME];
  assign acc_en  = cfg_q[`SFF_B_ACC];
  assign aux_en  = cfg_q[`SFF_B_AUX];
  assign unf_en  = cfg_q[`SFF_B_UNF];
  assign burst_n = cfg_q[`SFF_B_BURST +: 3];
  assign downs   = cfg_q[`SFF_B_DOWNS +: 3];
  assign hl_len  = (aux_en ? `SFF_AUX_BYTES : 5'd0) + (acc_en ? `SFF_ACC_BYTES : 5'd0) + {4'h0, ~(aux_en | acc_en)};
  assign tag     = {pin2_level & cfg_q[`SFF_B_TAG2] & cfg_q[`SFF_B_IN2],
                    pin1_level & cfg_q[`SFF_B_TAG1] & cfg_q[`SFF_B_IN1]}; // [R18]

  // Level, fill and interrupt conditions
  assign count    = wr_q - rd_q;           // [R10]
  assign free     = `SFF_DEPTH - count;
  assign lvl_full = count > `SFF_FULL_THR;       // [R19]
  assign lvl_wtm  = {3'b000, count} >= wtm_q;     // [R20]
  // Quiet from the first data port setup on, not only once the burst flag is up
  assign irq_full = full_q & ~burst_q & ~(psel & (paddr == `SFF_A_DATA)); // [R21]
  assign irq_wtm  = wtmf_q & ~burst_q & ~(psel & (paddr == `SFF_A_DATA)); // [R21]

  // Flush on command or on changes that alter frame layout
  assign cfg_wr = wr_en & (paddr == `SFF_A_CONFIG);
  always_comb begin
    flush = wr_en && (paddr == `SFF_A_CMD) && (pwdata[7:0] == `SFF_CMD_FLUSH); // [R22]
    if (cfg_wr) begin
      if (pwdata[`SFF_B_HDR] != hdr_en) flush = 1'b1;                              // [R22]
      if (!pwdata[`SFF_B_HDR] && (pwdata[`SFF_B_ACC +: 2] != cfg_q[`SFF_B_ACC +: 2])) flush = 1'b1; // [R02]
      if ((pwdata[`SFF_B_AUX] | aux_en) && (pwdata[`SFF_B_BURST +: 3] != burst_n)) flush = 1'b1; // [R22]
    end
  end

  // Rate selection and power-of-two downsampling of the accel input
  assign acc_src  = unf_en ? smp.raw_tick : smp.filt_tick;   // [R05]
  assign ds_mask  = (7'h01 << downs) - 7'h01;                // [R05]
  assign acc_take = acc_en & acc_src & ((ds_q & ds_mask) == 7'h00);
  assign aux_take = aux_en & smp.aux_tick;
  assign tick     = acc_take | aux_take;                     // [R04]
  assign ds_d     = flush ? 7'h00 : (acc_src ? ds_q + 7'h01 : ds_q);
  // Headerless keeps every enabled slot so all frames have one size
  assign inc_aux  = hdr_en ? aux_take : aux_en;              // [R01]
  assign inc_acc  = hdr_en ? acc_take : acc_en;
  assign drop_ok  = hdr_en & (trn_q | (pend_q != 4'h0)) & evt.drop_valid & ~tick; // [R14]

  // Register writes
  always_comb begin
    cfg_d = cfg_q;
    wtm_d = wtm_q;
    if (wr_en) begin
      unique case (paddr)
        `SFF_A_CONFIG: cfg_d = pwdata[15:0];
        `SFF_A_WTM_LO: wtm_d[7:0] = pwdata[7:0];
        `SFF_A_WTM_HI: wtm_d[13:8] = pwdata[5:0];
        default: ;
      endcase
    end
  end

  // Byte presented at the data port
  always_comb begin
    rs_e  = (!burst_q && hdr_en && skip_q != 8'h00) ? RS_SKIP : rs_q; // [R11]
    ri_e  = burst_q ? ri_q : 2'd0;
    have  = cur_q != wr_q;
    ovb   = (hdr_en ^ ov_q) ? `SFF_INVALID : 8'h00;                   // [R16]
    rbyte = 8'h00;
    unique case (rs_e)
      RS_SKIP: rbyte = (ri_e == 2'd0) ? {`SFF_HDR_CTL, `SFF_OP_SKIP, 2'b00} : skip_q; // [R09]
      RS_TIME: begin
        unique case (ri_e)
          2'd0: rbyte = {`SFF_HDR_CTL, `SFF_OP_TIME, 2'b00};
          2'd1: rbyte = tm_q[7:0];
          2'd2: rbyte = tm_q[15:8];
          2'd3: rbyte = tm_q[23:16];
        endcase
      end
      RS_DATA, RS_OVER: rbyte = have ? mem[cur_q[9:0]] : ovb;
    endcase
  end

  // Read data capture in the setup cycle
  always_comb begin
    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      unique case (paddr)
        `SFF_A_CONFIG: prdata_d = {16'h0000, cfg_q};
        `SFF_A_LEN_LO: prdata_d = {24'h000000, count[7:0]};   // [R10]
        `SFF_A_LEN_HI: prdata_d = {29'h00000000, count[10:8]};
        `SFF_A_DATA:   prdata_d = {24'h000000, rbyte};
        `SFF_A_WTM_LO: prdata_d = {24'h000000, wtm_q[7:0]};
        `SFF_A_WTM_HI: prdata_d = {26'h0000000, wtm_q[13:8]};
        `SFF_A_STATUS: prdata_d = {29'h00000000, err_q, wtmf_q, full_q};
        default:       prdata_d = 32'h00000000;
      endcase
    end
  end

  // Queue state: burst tracking, reader, writer, flush
  always_comb begin
    wr_d = wr_q; rd_d = rd_q; cur_d = cur_q; rem_d = rem_q; rs_d = rs_q; ri_d = ri_q;
    ov_d = ov_q; skip_d = skip_q; tm_d = tm_q; ws_d = ws_q; wi_d = wi_q; len_d = len_q;
    stg_d = stg_q; trn_d = trn_q; burst_d = burst_q; idle_d = idle_q;
    pend_d = hdr_en ? (pend_q | (evt.chg_valid ? evt.chg_bits : 4'h0)) : 4'h0;
    mem_we = 1'b0; mem_wa = wr_q[9:0]; mem_wd = stg_q[wi_q];
    skip_inc = 1'b0; err_set = 1'b0; rem_n = 5'd0; n = 0;
    // A burst ends on another access or after a quiet spell
    if (data_rd) begin
      burst_d = 1'b1;
      idle_d  = 4'h0;
    end else if (acc_ph) begin
      burst_d = 1'b0;
    end else if (!psel && burst_q) begin
      idle_d = idle_q + 4'h1;
      if (idle_q == `SFF_BURST_IDLE - 4'h1) burst_d = 1'b0;
    end
    // Reader: one byte per completed data read
    if (data_rd) begin
      unique case (rs_e)
        RS_SKIP: begin
          if (ri_e == 2'd0) begin
            rs_d = RS_SKIP;
            ri_d = 2'd1;
          end else begin
            rs_d   = RS_DATA;
            ri_d   = 2'd0;
            skip_d = 8'h00;
          end
        end
        RS_TIME: begin
          ri_d = ri_q + 2'd1;
          if (ri_q == 2'd3) rs_d = RS_OVER;
        end
        RS_DATA, RS_OVER: begin
          if (have) begin
            rem_n = (rem_q == 5'd0) ? flen(mem[cur_q[9:0]], hdr_en, hl_len) - 5'd1 : rem_q - 5'd1;
            cur_d = cur_q + 11'd1;
            rem_d = rem_n;
            rs_d  = RS_DATA;
            // Commit only at frame ends so a partial frame can be replayed
            if (rem_n == 5'd0) begin
              rd_d = cur_d; // [R15]
              if (cur_d == wr_q) begin
                if (hdr_en && time_en) begin
                  rs_d = RS_TIME; // [R12]
                  ri_d = 2'd0;
                  tm_d = sensortime;
                end else begin
                  rs_d = RS_OVER;
                end
              end
            end
          end else begin
            ov_d = ~ov_q; // [R16]
            rs_d = RS_OVER;
          end
        end
      endcase
    end
    // Writer; stalls while a data read is on the bus
    unique case (ws_q)
      WS_IDLE: begin
        if (hdr_en && pend_q != 4'h0 && (tick || drop_ok)) begin
          stg_d[0] = {`SFF_HDR_CTL, `SFF_OP_ICFG, tag}; // [R13]
          stg_d[1] = {2'b00, pend_q[3:2], 2'b00, pend_q[1:0]};
          n = 2;
          pend_d = evt.chg_valid ? evt.chg_bits : 4'h0;
          trn_d = 1'b1;
        end
        if (tick) begin
          if (hdr_en) begin
            stg_d[n] = {`SFF_HDR_REG, 1'b0, aux_take, 1'b0, acc_take, tag}; // [R23]
            n = n + 1;
          end
          if (inc_aux) begin
            for (int i = 0; i < 8; i++) begin
              stg_d[n + i] = (i <= int'(burst_n)) ? smp.aux_bytes[8 * i +: 8] : 8'h00; // [R03]
            end
            n = n + 8;
          end
          if (inc_acc) begin
            for (int i = 0; i < 6; i++) begin
              stg_d[n + i] = smp.acc_xyz[8 * i +: 8]; // [R03]
            end
            n = n + 6;
          end
          if (aux_take == aux_en && acc_take == acc_en) trn_d = 1'b0; // [R17]
        end else if (drop_ok) begin
          stg_d[n]     = {`SFF_HDR_CTL, `SFF_OP_DROP, tag}; // [R14]
          stg_d[n + 1] = {5'b00000, evt.drop_bits[1], 1'b0, evt.drop_bits[0]};
          n = n + 2;
        end
        if (n != 0) begin
          ws_d  = WS_EVICT;
          len_d = 5'(n);
        end
      end
      WS_EVICT: begin
        if (!data_sel) begin
          if (free >= `SFF_MAX_FRAME) begin
            ws_d = WS_WRITE;
            wi_d = 5'd0;
          end else if (stop_en || burst_q) begin
            skip_inc = 1'b1; // [R07]
            err_set  = burst_q; // [R08]
            ws_d     = WS_IDLE;
          end else begin
            rd_d     = rd_q + {6'h00, flen(mem[rd_q[9:0]], hdr_en, hl_len)}; // [R06]
            skip_inc = 1'b1;
          end
        end
      end
      WS_WRITE: begin
        if (!data_sel) begin
          mem_we = 1'b1;
          wr_d   = wr_q + 11'd1;
          wi_d   = wi_q + 5'd1;
          if (wi_q == len_q - 5'd1) ws_d = WS_IDLE;
        end
      end
    endcase
    // Skip count saturates; a new skip wins over the read clear
    if (skip_inc && skip_d != 8'hFF) skip_d = skip_d + 8'h01; // [R11]
    // Outside a burst the cursor rests on the last committed frame
    if (!burst_d) begin
      rs_d  = RS_DATA;
      ri_d  = 2'd0;
      ov_d  = 1'b0;
      rem_d = 5'd0;
      cur_d = rd_d; // [R15]
    end
    if (flush) begin
      wr_d = 11'd0; rd_d = 11'd0; cur_d = 11'd0; rem_d = 5'd0; // [R22]
      skip_d = 8'h00; ws_d = WS_IDLE; rs_d = RS_DATA; ri_d = 2'd0; trn_d = 1'b0;
      mem_we = 1'b0;
    end
  end

  // Latched status; set wins over the read clear
  always_comb begin
    full_d = full_q;
    wtmf_d = wtmf_q;
    err_d  = err_q;
    if (rd_en && paddr == `SFF_A_STATUS) begin
      if (!lvl_full) full_d = 1'b0; // [R21]
      if (!lvl_wtm) wtmf_d = 1'b0;  // [R21]
      err_d = 1'b0;
    end
    if (lvl_full && !burst_q) full_d = 1'b1; // [R19]
    if (lvl_wtm && !burst_q) wtmf_d = 1'b1;  // [R20]
    if (err_set) err_d = 1'b1;               // [R08]
  end

  // Storage array, no reset needed for payload
  always_ff @(posedge clk_sys) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  // State registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cfg_q <= `SFF_CFG_RST; wtm_q <= 14'h0000; prdata_q <= 32'h00000000;
      wr_q <= 11'd0; rd_q <= 11'd0; cur_q <= 11'd0; rem_q <= 5'd0;
      rs_q <= RS_DATA; ri_q <= 2'd0; ov_q <= 1'b0; skip_q <= 8'h00; tm_q <= 24'h000000;
      ws_q <= WS_IDLE; wi_q <= 5'd0; len_q <= 5'd0; pend_q <= 4'h0; trn_q <= 1'b0;
      burst_q <= 1'b0; idle_q <= 4'h0; ds_q <= 7'h00;
      full_q <= 1'b0; wtmf_q <= 1'b0; err_q <= 1'b0;
      for (int i = 0; i < 17; i++) stg_q[i] <= 8'h00;
    end else begin
      cfg_q <= cfg_d; wtm_q <= wtm_d; prdata_q <= prdata_d;
      wr_q <= wr_d; rd_q <= rd_d; cur_q <= cur_d; rem_q <= rem_d;
      rs_q <= rs_d; ri_q <= ri_d; ov_q <= ov_d; skip_q <= skip_d; tm_q <= tm_d;
      ws_q <= ws_d; wi_q <= wi_d; len_q <= len_d; pend_q <= pend_d; trn_q <= trn_d;
      burst_q <= burst_d; idle_q <= idle_d; ds_q <= ds_d;
      full_q <= full_d; wtmf_q <= wtmf_d; err_q <= err_d;
      for (int i = 0; i < 17; i++) stg_q[i] <= stg_d[i];
    end
  end
endmodule : sff_top

// ---- sim/sff_top_assertions.sv ----
// Port checker of the frame queue: bus answers, flush and interrupt flags.
// Assumes it is bound to sff_top and sees only that module's ports.
`timescale 1ns/1ps
`include "sff_cfg.svh"
module sff_checker (
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire sff_pkg::sff_sample_t smp,
  input wire sff_pkg::sff_event_t  evt,
  input wire logic [23:0]          sensortime,
  input wire logic                 pin1_level,
  input wire logic                 pin2_level,
  input wire logic                 irq_full,
  input wire logic                 irq_wtm
);
  import sff_pkg::*;
  logic acc_phase;
  logic flushed_q;
  logic flushed_d;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Access phase of any transfer
  assign acc_phase = psel && penable;
  // Queue known empty: flush seen, no tick or event since
  always_comb begin
    flushed_d = flushed_q;
    if (smp.filt_tick || smp.raw_tick || smp.aux_tick || evt.chg_valid || evt.drop_valid) begin
      flushed_d = 1'h0;
    end
    if (acc_phase && pwrite && paddr == `SFF_A_CMD && pwdata[7:0] == `SFF_CMD_FLUSH) begin
      flushed_d = 1'h1;
    end
  end
  // Cleared in reset so a stale flush never arms the check
  always_ff @(posedge clk_sys) begin
    flushed_q <= nrst ? flushed_d : 1'h0;
  end
  chk_ready_now: assert property (pready == acc_phase)
    else $error("pready differs from access phase");
  chk_bad_addr: assert property (acc_phase && (paddr[11:6] != 6'h0 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without slave error");
  chk_bad_rdata: assert property (acc_phase && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  chk_data_byte: assert property (acc_phase && !pwrite && paddr == `SFF_A_DATA |-> prdata[31:8] == 24'h0)
    else $error("queue data wider than a byte");
  chk_len_width: assert property (acc_phase && !pwrite && paddr == `SFF_A_LEN_HI |-> prdata[31:3] == 29'h0)
    else $error("fill level above storage size");
  chk_flush_empty: assert property (flushed_q && acc_phase && !pwrite && paddr[11:3] == 9'h1 |-> prdata == 32'h0)
    else $error("fill level not zero after flush");
  chk_burst_quiet: assert property (acc_phase && paddr == `SFF_A_DATA |-> !irq_full && !irq_wtm)
    else $error("queue interrupt during data read");
  chk_full_clear: assert property ($fell(irq_full) |-> $past(acc_phase && (paddr == `SFF_A_STATUS
    || paddr == `SFF_A_DATA)) || (psel && paddr == `SFF_A_DATA))
    else $error("full interrupt dropped without cause");
  chk_wtm_clear: assert property ($fell(irq_wtm) |-> $past(acc_phase && (paddr == `SFF_A_STATUS
    || paddr == `SFF_A_DATA)) || (psel && paddr == `SFF_A_DATA))
    else $error("watermark interrupt dropped without cause");
  chk_reset_clean: assert property ($rose(nrst) |-> prdata == 32'h0 && !irq_full && !irq_wtm)
    else $error("outputs not clear after reset");
  cover property ($rose(irq_full));
  cover property ($rose(irq_wtm));
  cover property (flushed_q && acc_phase && paddr == `SFF_A_LEN_LO);
  cover property (acc_phase && pslverr);
endmodule : sff_checker

bind sff_top sff_checker i_chk (
  .clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .smp, .evt, .sensortime, .pin1_level, .pin2_level, .irq_full, .irq_wtm);

// ---- sim/sff_host_model.sv ----
// Host processor model: APB master cycles on request of the bench.
// Assumes one clock; the slave may answer with up to 63 wait states.
`timescale 1ns/1ps
module sff_host_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic             hung
);
  // Bus idle at time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hung = 1'h0;
  end
  // Setup, then access held until pready; bounded so a dead slave ends the run
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 64);
    q = prdata;
    e = pslverr;
    hung <= (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    pwdata <= ~d; // Released data no longer shows the old value
  endtask : xfer
endmodule : sff_host_model

// ---- sim/sff_top_test.sv ----
// Self-checking bench of the frame queue: sensor ticks and register traffic.
// Assumes the host model for bus cycles and the checker bound to sff_top.
`timescale 1ns/1ps
`include "sff_cfg.svh"
module sff_top_test;
  import sff_pkg::*;
  typedef logic [7:0] sff_bytes_t [$];
  logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, rerr, hung;
  logic        pin1_level, pin2_level, irq_full, irq_wtm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [23:0] sensortime;
  sff_sample_t smp;
  sff_event_t  evt;
  int          miscompares, total_checks;
  sff_top i_dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .smp, .evt, .sensortime, .pin1_level, .pin2_level, .irq_full, .irq_wtm);
  sff_host_model i_host (.clk_sys, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata, .hung);
  // 20 MHz clock
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'h1, a, d, rdat, rerr);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    i_host.xfer(1'h0, a, 32'h0, rdat, rerr);
    check(rdat, exp);
  endtask : rd
  // A run of data port reads forms one burst
  task automatic drain(input sff_bytes_t e);
    foreach (e[i]) rd(`SFF_A_DATA, {24'h0, e[i]});
  endtask : drain
  // One tick, then room for the writer's longest frame
  task automatic tick();
    @(posedge clk_sys);
    smp.filt_tick <= 1'h1;
    @(posedge clk_sys);
    smp.filt_tick <= 1'h0;
    repeat (20) @(posedge clk_sys);
  endtask : tick
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // Dead bus or runaway run
  always @(posedge hung) begin
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
  initial begin
    nrst = 1'h0;
    smp = '0;
    evt = '0;
    smp.acc_xyz = 48'h665544332211;
    sensortime = 24'hC3B2A1;
    pin1_level = 1'h1;
    pin2_level = 1'h0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h1;
    rd(`SFF_A_CONFIG, 32'h9);
    rd(`SFF_A_LEN_LO, 32'h0);
    rd(`SFF_A_STATUS, 32'h2);
    rd(12'h040, 32'h0);
    check({31'h0, rerr}, 32'h1);
    $display("Test reset done");
    // Tagged frame, cut short then replayed whole, sensortime and overread
    wr(`SFF_A_WTM_LO, 32'h7);
    rd(`SFF_A_STATUS, 32'h2);
    wr(`SFF_A_CONFIG, 32'hAD);
    tick();
    rd(`SFF_A_LEN_LO, 32'h7);
    check({31'h0, irq_wtm}, 32'h1);
    drain('{8'h85, 8'h11, 8'h22});
    rd(`SFF_A_CONFIG, 32'hAD);
    drain('{8'h85, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h44, 8'hA1, 8'hB2, 8'hC3, 8'h80, 8'h00});
    rd(`SFF_A_STATUS, 32'h2);
    rd(`SFF_A_STATUS, 32'h0);
    $display("Test frame read done");
    // Config change, then a drop, then a regular frame
    @(posedge clk_sys);
    evt.chg_valid <= 1'h1;
    evt.chg_bits <= 4'h3;
    @(posedge clk_sys);
    evt.chg_valid <= 1'h0;
    repeat (5) @(posedge clk_sys);
    evt.drop_valid <= 1'h1;
    evt.drop_bits <= 2'h1;
    @(posedge clk_sys);
    evt.drop_valid <= 1'h0;
    repeat (20) @(posedge clk_sys);
    tick();
    rd(`SFF_A_LEN_LO, 32'hB);
    drain('{8'h49, 8'h03, 8'h51, 8'h01, 8'h85, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h44, 8'hA1, 8'hB2, 8'hC3, 8'h80});
    $display("Test control frames done");
    tick();
    wr(`SFF_A_CMD, 32'hB0);
    rd(`SFF_A_LEN_LO, 32'h0);
    $display("Test flush done");
    // Stop mode: 144 frames of 7 fit before free space drops below 17
    wr(`SFF_A_CONFIG, 32'hAF);
    repeat (150) tick();
    rd(`SFF_A_LEN_LO, 32'hF0);
    rd(`SFF_A_LEN_HI, 32'h3);
    check({31'h0, irq_full}, 32'h1);
    drain('{8'h40, 8'h06});
    $display("Test overflow done");
    // Headerless, divide by two: header switch flushes the full queue
    wr(`SFF_A_CONFIG, 32'h2008);
    rd(`SFF_A_LEN_HI, 32'h0);
    tick();
    tick();
    rd(`SFF_A_LEN_LO, 32'h6);
    drain('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00, 8'h80});
    $display("Test headerless done");
    complete_run();
  end
endmodule : sff_top_test
